// ==== design/core_subset_cfg.svh ====
// offsets, field positions and reset values of the instruction subset core
`ifndef CORE_SUBSET_CFG_SVH
`define CORE_SUBSET_CFG_SVH
// register port map
`define ADDR_FILE_LAST 6'h1F
`define ADDR_ACC 6'h20
`define ADDR_OPTION 6'h21
`define ADDR_STATUS 6'h22
`define ADDR_PC_LOW 6'h23
// status field positions
`define STAT_CARRY 0
`define STAT_DIGIT_CARRY 1
`define STAT_ZERO 2
`define STAT_POWERDOWN 3
`define STAT_TIMEOUT 4
`define STAT_WAKE 7
// reset values and program counter step
`define RST_ACC 8'h00
`define RST_OPTION 8'hFF
`define RST_FILE 8'h00
`define RST_PC 9'h000
`define RST_TIMEOUT 1'b1
`define RST_POWERDOWN 1'b1
`define PC_STEP 9'h001
`endif

// ==== design/core_subset_pkg.sv ====
// types shared by the instruction subset core and its bench
`default_nettype none
package core_subset_pkg;
  typedef enum logic [2:0] {
    no_operation_instr,
    load_literal_instr,
    load_option_instr,
    return_with_literal_instr,
    sleep_instr,
    rotate_left_carry_instr,
    rotate_right_carry_instr,
    subtract_acc_from_file_instr
  } op_t;
  typedef struct packed {
    op_t op;
    logic [7:0] literal;
    logic [4:0] faddr;
    logic dest;
  } instr_req_t;
endpackage
`default_nettype wire

// ==== design/core_instruction_subset.sv ====
// execution core for a subset of an 8-bit instruction set
// Operation
// (RULE1) literal load puts the 8-bit immediate in the accumulator, flags untouched
// (RULE2) option load copies the accumulator into the option register, flags untouched
// (RULE3) return loads immediate into accumulator and program counter from stack top
// (RULE4) return takes two instruction cycles
// (RULE5) sleep clears the watchdog counter and its prescaler
// (RULE6) sleep sets timeout flag, clears powerdown flag, keeps wake flag
// (RULE7) after sleep the oscillator halts and execution stops until wake-up
// (RULE8) rotate left through carry on file register 0..31, only carry changes
// (RULE9) rotate right through carry, only carry changes
// (RULE10) subtract accumulator from file register, update carry, digit carry, zero
// (RULE11) destination 0 writes accumulator, destination 1 writes the file register
// (RULE12) bit shifted out becomes carry, old carry fills the vacated end
// (RULE13) no-operation takes one cycle and only advances the program counter
`timescale 1ns/100ps
`default_nettype none
`include "core_subset_cfg.svh"
module core_instruction_subset
  import core_subset_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // instruction issue
  input wire logic INSTR_VALID,
  input wire instr_req_t INSTR,
  output logic INSTR_READY,
  // stack and program counter
  input wire logic [8:0] STACK_TOP,
  output logic STACK_POP,
  output logic [8:0] PC,
  // watchdog and power
  output logic WATCHDOG_COUNTER_CLEAR,
  output logic PRESCALER_CLEAR,
  output logic OSC_HALT,
  input wire logic WAKE_PIN,
  // register port
  input wire logic [5:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA
);

  typedef enum logic [1:0] {run, return_wait, asleep} state_t;
  state_t state;
  logic [7:0] file_mem [0:31];
  logic [7:0] acc;
  logic [7:0] option_reg;
  logic carry_flag;
  logic digit_carry_flag;
  logic zero_flag;
  logic timeout_status_flag;
  logic powerdown_status_flag;
  logic pin_change_wake_flag;
  logic wake_meta;
  logic wake_sync;
  logic wake_prev;
  logic wake_event;
  logic accept;
  logic is_alu;
  logic [7:0] sel_val;
  logic [7:0] alu_res;
  logic next_c;
  logic next_digit_carry;
  logic next_z;
  logic [8:0] diff;
  logic [4:0] nib_diff;
  logic [7:0] status_byte;
  logic file_hit;

  // ****************************************
  // handshake and decode
  // ****************************************
  assign INSTR_READY = (state == run);
  assign accept = INSTR_VALID && INSTR_READY;
  assign is_alu = (INSTR.op == rotate_left_carry_instr) || (INSTR.op == rotate_right_carry_instr) ||
                  (INSTR.op == subtract_acc_from_file_instr);
  assign file_hit = (REG_ADDR <= `ADDR_FILE_LAST);
  // the first flop is never looked at; second against third flop gives the change
  assign wake_event = wake_sync ^ wake_prev;

  always_comb begin
    sel_val = file_mem[INSTR.faddr];
    diff = {1'b0, sel_val} - {1'b0, acc};
    nib_diff = {1'b0, sel_val[3:0]} - {1'b0, acc[3:0]};
    alu_res = 8'h00;
    next_c = carry_flag;
    next_digit_carry = digit_carry_flag;
    next_z = zero_flag;
    case (INSTR.op)
      rotate_left_carry_instr: begin
        alu_res = {sel_val[6:0], carry_flag}; // see RULE8 see RULE12
        next_c = sel_val[7];
      end
      rotate_right_carry_instr: begin
        alu_res = {carry_flag, sel_val[7:1]}; // see RULE9 see RULE12
        next_c = sel_val[0];
      end
      subtract_acc_from_file_instr: begin
        alu_res = diff[7:0]; // see RULE10
        next_c = ~diff[8];
        next_digit_carry = ~nib_diff[4];
        next_z = (diff[7:0] == 8'h00);
      end
      default: begin
        alu_res = 8'h00;
      end
    endcase
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state <= run;
    end else begin
      case (state)
        run: begin
          if (accept && INSTR.op == return_with_literal_instr) begin
            state <= return_wait; // see RULE4
          end else if (accept && INSTR.op == sleep_instr) begin
            state <= asleep; // see RULE7
          end
        end
        return_wait: begin
          state <= run;
        end
        asleep: begin
          if (wake_event) begin
            state <= run;
          end
        end
        default: begin
          state <= run;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
      wake_prev <= 1'b0;
    end else begin
      wake_meta <= WAKE_PIN;
      wake_sync <= wake_meta;
      wake_prev <= wake_sync;
    end
  end

  // ****************************************
  // accumulator, option and file registers
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      acc <= `RST_ACC;
    end else if (accept && (INSTR.op == load_literal_instr || INSTR.op == return_with_literal_instr)) begin
      acc <= INSTR.literal; // see RULE1 see RULE3
    end else if (accept && is_alu && !INSTR.dest) begin
      acc <= alu_res; // see RULE11
    end else if (REG_WR && REG_ADDR == `ADDR_ACC) begin
      acc <= REG_WDATA;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      option_reg <= `RST_OPTION;
    end else if (accept && INSTR.op == load_option_instr) begin
      option_reg <= acc; // see RULE2
    end else if (REG_WR && REG_ADDR == `ADDR_OPTION) begin
      option_reg <= REG_WDATA;
    end
  end

  // instruction write-back wins over a colliding port write
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 32; i++) begin
        file_mem[i] <= `RST_FILE;
      end
    end else if (accept && is_alu && INSTR.dest) begin
      file_mem[INSTR.faddr] <= alu_res; // see RULE11
    end else if (REG_WR && file_hit) begin
      file_mem[REG_ADDR[4:0]] <= REG_WDATA;
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
    end else if (accept && is_alu) begin
      carry_flag <= next_c; // see RULE8 see RULE9 see RULE10
      digit_carry_flag <= next_digit_carry;
      zero_flag <= next_z;
    end else if (REG_WR && REG_ADDR == `ADDR_STATUS) begin
      carry_flag <= REG_WDATA[`STAT_CARRY];
      digit_carry_flag <= REG_WDATA[`STAT_DIGIT_CARRY];
      zero_flag <= REG_WDATA[`STAT_ZERO];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      timeout_status_flag <= `RST_TIMEOUT;
      powerdown_status_flag <= `RST_POWERDOWN;
    end else if (accept && INSTR.op == sleep_instr) begin
      timeout_status_flag <= 1'b1; // see RULE6
      powerdown_status_flag <= 1'b0;
    end
  end

  // set by a pin wake-up, cleared by writing zero; the set wins
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_change_wake_flag <= 1'b0;
    end else if (state == asleep && wake_event) begin
      pin_change_wake_flag <= 1'b1;
    end else if (REG_WR && REG_ADDR == `ADDR_STATUS && !REG_WDATA[`STAT_WAKE]) begin
      pin_change_wake_flag <= 1'b0;
    end
  end

  // ****************************************
  // program counter, stack and power outputs
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PC <= `RST_PC;
    end else if (state == return_wait) begin
      PC <= STACK_TOP; // see RULE3
    end else if (accept && INSTR.op != return_with_literal_instr) begin
      PC <= PC + `PC_STEP; // see RULE13
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      STACK_POP <= 1'b0;
      WATCHDOG_COUNTER_CLEAR <= 1'b0;
      PRESCALER_CLEAR <= 1'b0;
    end else begin
      STACK_POP <= accept && INSTR.op == return_with_literal_instr;
      WATCHDOG_COUNTER_CLEAR <= accept && INSTR.op == sleep_instr; // see RULE5
      PRESCALER_CLEAR <= accept && INSTR.op == sleep_instr;
    end
  end

  // halt is held until the synchronised pin changes
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      OSC_HALT <= 1'b0;
    end else if (accept && INSTR.op == sleep_instr) begin
      OSC_HALT <= 1'b1; // see RULE7
    end else if (state == asleep && wake_event) begin
      OSC_HALT <= 1'b0;
    end
  end

  // ****************************************
  // register port read
  // ****************************************
  always_comb begin
    status_byte = 8'h00;
    status_byte[`STAT_CARRY] = carry_flag;
    status_byte[`STAT_DIGIT_CARRY] = digit_carry_flag;
    status_byte[`STAT_ZERO] = zero_flag;
    status_byte[`STAT_POWERDOWN] = powerdown_status_flag;
    status_byte[`STAT_TIMEOUT] = timeout_status_flag;
    status_byte[`STAT_WAKE] = pin_change_wake_flag;
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      if (file_hit) begin
        REG_RDATA <= file_mem[REG_ADDR[4:0]];
      end else if (REG_ADDR == `ADDR_ACC) begin
        REG_RDATA <= acc;
      end else if (REG_ADDR == `ADDR_OPTION) begin
        REG_RDATA <= option_reg;
      end else if (REG_ADDR == `ADDR_STATUS) begin
        REG_RDATA <= status_byte;
      end else if (REG_ADDR == `ADDR_PC_LOW) begin
        REG_RDATA <= PC[7:0];
      end else begin
        REG_RDATA <= 8'h00;
      end
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  AST_LOAD_LIT: assert property ( // see RULE1
    accept && INSTR.op == load_literal_instr && !REG_WR |=>
      acc == $past(INSTR.literal) && $stable(carry_flag) && $stable(zero_flag) && $stable(digit_carry_flag))
    else $error("literal load wrong");

  AST_OPTION: assert property ( // see RULE2
    accept && INSTR.op == load_option_instr && !REG_WR |=> option_reg == $past(acc) && $stable(status_byte))
    else $error("option load wrong");

  AST_RET_PC: assert property ( // see RULE3
    accept && INSTR.op == return_with_literal_instr |=>
      acc == $past(INSTR.literal) && STACK_POP ##1 PC == $past(STACK_TOP))
    else $error("return did not load literal and stack top");

  AST_RET_TWO: assert property ( // see RULE4
    accept && INSTR.op == return_with_literal_instr |=> !INSTR_READY ##1 INSTR_READY)
    else $error("return not two cycles");

  AST_SLEEP_WATCHDOG: assert property ( // see RULE5
    accept && INSTR.op == sleep_instr |=> WATCHDOG_COUNTER_CLEAR && PRESCALER_CLEAR ##1 !WATCHDOG_COUNTER_CLEAR)
    else $error("sleep did not clear watchdog");

  AST_SLEEP_FLAGS: assert property ( // see RULE6
    accept && INSTR.op == sleep_instr && !REG_WR |=>
      timeout_status_flag && !powerdown_status_flag && $stable(pin_change_wake_flag))
    else $error("sleep flags wrong");

  AST_SLEEP_HALT: assert property ( // see RULE7
    accept && INSTR.op == sleep_instr |=> OSC_HALT && !INSTR_READY)
    else $error("sleep did not halt");

  AST_ROT_LEFT: assert property ( // see RULE8
    accept && INSTR.op == rotate_left_carry_instr && !INSTR.dest |=>
      acc == {$past(sel_val[6:0]), $past(carry_flag)} && carry_flag == $past(sel_val[7]))
    else $error("rotate left wrong");

  AST_ROT_RIGHT: assert property ( // see RULE9
    accept && INSTR.op == rotate_right_carry_instr && !INSTR.dest |=>
      acc == {$past(carry_flag), $past(sel_val[7:1])} && carry_flag == $past(sel_val[0]))
    else $error("rotate right wrong");

  AST_SUB_FLAGS: assert property ( // see RULE10
    accept && INSTR.op == subtract_acc_from_file_instr |=>
      carry_flag == ($past(sel_val) >= $past(acc)) && zero_flag == ($past(sel_val) == $past(acc)))
    else $error("subtract flags wrong");

  AST_DEST_FILE: assert property ( // see RULE11
    accept && is_alu && INSTR.dest && !REG_WR |=> acc == $past(acc))
    else $error("file destination changed accumulator");

  AST_NO_OPERATION: assert property ( // see RULE13
    accept && INSTR.op == no_operation_instr && !REG_WR |=>
      PC == $past(PC) + `PC_STEP && $stable(acc) && $stable(status_byte) && INSTR_READY)
    else $error("no-operation changed state");
  COV_RETURN: cover property (accept && INSTR.op == return_with_literal_instr ##2 INSTR_READY);
  COV_SLEEP_WAKE: cover property (OSC_HALT ##[1:20] !OSC_HALT);
  COV_SUB_FILE: cover property (accept && INSTR.op == subtract_acc_from_file_instr && INSTR.dest);
  COV_ROT_ACC: cover property (accept && INSTR.op == rotate_left_carry_instr && !INSTR.dest);
endmodule
`default_nettype wire

// ==== testbench/core_instruction_subset_bench.sv ====
// self-checking bench for the instruction subset core
`timescale 1ns/100ps
`default_nettype none
`include "core_subset_cfg.svh"
module core_instruction_subset_bench
  import core_subset_pkg::*;
;
  // ****************************************
  // signals and design
  // ****************************************
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  instr_req_t instr = '0;
  logic instr_ready;
  logic [8:0] stack_top = 9'h000;
  logic stack_pop;
  logic [8:0] pc;
  logic watchdog_clear;
  logic pre_clear;
  logic osc_halt;
  logic wake_pin = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  typedef struct {op_t op; logic [7:0] k; logic [4:0] f; logic d; logic [7:0] acc; logic [7:0] fv; logic [7:0] st;} row_t;
  row_t rows [12];

  core_instruction_subset DUT (
    .REF_CLK(ref_clk), .RST(rst), .INSTR_VALID(instr_valid), .INSTR(instr), .INSTR_READY(instr_ready),
    .STACK_TOP(stack_top), .STACK_POP(stack_pop), .PC(pc), .WATCHDOG_COUNTER_CLEAR(watchdog_clear),
    .PRESCALER_CLEAR(pre_clear), .OSC_HALT(osc_halt), .WAKE_PIN(wake_pin), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata)
  );

  always #25 ref_clk = ~ref_clk;

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic reg_wr_t(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_chk(input logic [5:0] a, input logic [7:0] exp, input string msg);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk({1'b0, reg_rdata}, {1'b0, exp}, msg);
  endtask

  task automatic issue(input op_t op, input logic [7:0] k, input logic [4:0] f, input logic d);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr <= '{op: op, literal: k, faddr: f, dest: d};
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard: the whole run needs well under 1000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      finish_test();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    // status 0x18: timeout and powerdown set after reset
    rows[0] = '{load_literal_instr, 8'h3C, 5'h05, 1'b0, 8'h3C, 8'h81, 8'h18};
    rows[1] = '{rotate_left_carry_instr, 8'h00, 5'h05, 1'b1, 8'h3C, 8'h02, 8'h19};
    rows[2] = '{rotate_right_carry_instr, 8'h00, 5'h05, 1'b0, 8'h81, 8'h02, 8'h18};
    rows[3] = '{rotate_left_carry_instr, 8'h00, 5'h1F, 1'b0, 8'h20, 8'h10, 8'h18};
    rows[4] = '{subtract_acc_from_file_instr, 8'h00, 5'h1F, 1'b1, 8'h20, 8'hF0, 8'h1A};
    rows[5] = '{subtract_acc_from_file_instr, 8'h00, 5'h05, 1'b0, 8'hE2, 8'h02, 8'h1A};
    rows[6] = '{load_literal_instr, 8'h02, 5'h05, 1'b0, 8'h02, 8'h02, 8'h1A};
    rows[7] = '{subtract_acc_from_file_instr, 8'h00, 5'h05, 1'b0, 8'h00, 8'h02, 8'h1F};
    rows[8] = '{no_operation_instr, 8'hA5, 5'h05, 1'b1, 8'h00, 8'h02, 8'h1F};
    rows[9] = '{rotate_right_carry_instr, 8'h00, 5'h05, 1'b1, 8'h00, 8'h81, 8'h1E};
    rows[10] = '{load_literal_instr, 8'hFF, 5'h05, 1'b0, 8'hFF, 8'h81, 8'h1E};
    // nibble borrow and full borrow: carry stays 0, digit carry and zero drop to 0
    rows[11] = '{subtract_acc_from_file_instr, 8'h00, 5'h05, 1'b0, 8'h82, 8'h81, 8'h18};
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk({8'h00, instr_ready}, 9'h001, "ready after reset");
    chk(pc, 9'h000, "pc after reset");
    reg_chk(`ADDR_OPTION, 8'hFF, "option reset");
    reg_chk(`ADDR_STATUS, 8'h18, "status reset");
    reg_wr_t(6'h05, 8'h81);
    reg_wr_t(6'h1F, 8'h10);
    $display("test reset done");
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].k, rows[i].f, rows[i].d);
      chk(pc, 9'(i + 1), "pc advance");
      reg_chk(`ADDR_ACC, rows[i].acc, "accumulator");
      reg_chk({1'b0, rows[i].f}, rows[i].fv, "file register");
      reg_chk(`ADDR_STATUS, rows[i].st, "status flags");
    end
    $display("test instruction table done");
    // flags back to carry 0, digit carry 1, zero 1 for the later status checks
    reg_wr_t(`ADDR_STATUS, 8'h06);
    reg_wr_t(`ADDR_OPTION, 8'h00);
    reg_wr_t(`ADDR_ACC, 8'hC3);
    reg_chk(`ADDR_ACC, 8'hC3, "accumulator port write");
    issue(load_literal_instr, 8'h5A, 5'h00, 1'b0);
    issue(load_option_instr, 8'h00, 5'h00, 1'b0);
    reg_chk(`ADDR_OPTION, 8'h5A, "option load");
    reg_chk(`ADDR_STATUS, 8'h1E, "option flags");
    reg_chk(6'h30, 8'h00, "unmapped read");
    $display("test option done");
    stack_top <= 9'h123;
    issue(return_with_literal_instr, 8'h77, 5'h00, 1'b0);
    chk({8'h00, stack_pop}, 9'h001, "stack pop");
    chk({8'h00, instr_ready}, 9'h000, "second return cycle");
    @(posedge ref_clk);
    #1;
    chk(pc, 9'h123, "return address");
    chk({8'h00, instr_ready}, 9'h001, "ready after return");
    reg_chk(`ADDR_ACC, 8'h77, "return literal");
    reg_chk(`ADDR_PC_LOW, 8'h23, "pc low byte after return");
    reg_chk(`ADDR_STATUS, 8'h1E, "return flags");
    $display("test return done");
    issue(sleep_instr, 8'h00, 5'h00, 1'b0);
    chk({7'h00, watchdog_clear, pre_clear}, 9'h003, "watchdog clears");
    chk({7'h00, osc_halt, instr_ready}, 9'h002, "halt on sleep");
    chk(pc, 9'h124, "pc after sleep");
    reg_chk(`ADDR_STATUS, 8'h16, "sleep flags");
    chk({7'h00, watchdog_clear, pre_clear}, 9'h000, "clears are pulses");
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr <= '{op: load_literal_instr, literal: 8'h11, faddr: 5'h00, dest: 1'b0};
    repeat (4) @(posedge ref_clk);
    #1;
    chk({7'h00, osc_halt, instr_ready}, 9'h002, "still asleep");
    chk(pc, 9'h124, "no execution asleep");
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    wake_pin <= 1'b1;
    for (int n = 0; n < 10 && osc_halt !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({8'h00, osc_halt}, 9'h000, "woken by pin");
    reg_chk(`ADDR_ACC, 8'h77, "no instruction taken asleep");
    reg_chk(`ADDR_STATUS, 8'h96, "wake flag");
    reg_wr_t(`ADDR_STATUS, 8'h18);
    reg_chk(`ADDR_STATUS, 8'h10, "status write, read-only bits");
    issue(sleep_instr, 8'h00, 5'h00, 1'b0);
    wake_pin <= 1'b0;
    for (int n = 0; n < 10 && osc_halt !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    reg_chk(`ADDR_STATUS, 8'h90, "second wake");
    $display("test sleep done");
    // second reset in mid-run with a value already in the accumulator
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(pc, 9'h000, "pc second reset");
    reg_chk(`ADDR_ACC, 8'h00, "acc second reset");
    reg_chk(`ADDR_STATUS, 8'h18, "status second reset");
    $display("test second reset done");
    finish_test();
  end
endmodule
`default_nettype wire
